// ---- verilog/device_bay_control_enable.sv ----
// Control, status and interrupt logic of one removable device bay
//
// Our own choice: the Wishbone register port.
module device_bay_control_enable
    import bay_ctrl_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
)
(
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    // Wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [ADDR_WIDTH-1:0] wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    // Bay pins
    input  wire logic [1:0]            presencePins,
    input  wire logic                  removalButton,
    output logic                       bayPower,
    output logic                       bayInterlock,
    output logic      [2:0]            bayActualState,
    // Interrupts
    output logic                       bayIrq,
    output logic                       irq
);

    logic [CTRL_WIDTH-1:0] ctrl;
    logic                  busReq;
    logic                  busWrite;
    logic                  busRead;
    logic                  lowByte;
    logic                  hitCtrl;
    logic                  hitStatus;
    logic                  hitEvent;
    logic                  hitMask;
    logic [31:0]           readData;
    logic [2:0]            syncPins;
    logic [1:0]            presNow;
    logic [1:0]            presPrev;
    logic                  buttonNow;
    logic                  buttonPrev;
    logic                  presChange;
    logic                  removalEvt;
    logic                  insertEvt;
    logic                  chgSet;
    logic                  btnSet;
    logic                  removalButtonFlag;
    logic                  statusChangeFlag;
    logic                  reqPending;
    bayState_type          state;
    bayState_type          next_state;
    logic                  stateChanged;
    logic [EVT_WIDTH-1:0]  eventStatus;
    logic [EVT_WIDTH-1:0]  eventMask;
    logic [EVT_WIDTH-1:0]  newEvents;
    logic [2:0]            requestedCode;

    // Valid target codes are 001 to 100
    function automatic logic codeValid(input logic [2:0] code);
        logic ok;
        ok = 1'b0;
        case (code)
            CODE_INSERTED,
            CODE_ENABLED,
            CODE_REM_REQ,
            CODE_REM_ALLOWED: ok = 1'b1;
            default:          ok = 1'b0;
        endcase
        return ok;
    endfunction

    function automatic bayState_type codeToState(input logic [2:0] code);
        bayState_type s;
        s = ST_EMPTY;
        case (code)
            CODE_INSERTED:    s = ST_INSERTED;
            CODE_ENABLED:     s = ST_ENABLED;
            CODE_REM_REQ:     s = ST_REM_REQ;
            CODE_REM_ALLOWED: s = ST_REM_ALLOWED;
            default:          s = ST_EMPTY;
        endcase
        return s;
    endfunction

    function automatic logic [2:0] stateToCode(input bayState_type s);
        logic [2:0] c;
        c = CODE_EMPTY;
        case (s)
            ST_EMPTY:       c = CODE_EMPTY;
            ST_INSERTED:    c = CODE_INSERTED;
            ST_ENABLED:     c = CODE_ENABLED;
            ST_REM_REQ:     c = CODE_REM_REQ;
            ST_REM_ALLOWED: c = CODE_REM_ALLOWED;
            default:        c = CODE_EMPTY;
        endcase
        return c;
    endfunction

    // Bus decode; writes land at the ack edge, a read acts where it captures
    assign busReq    = wb_cyc_i & wb_stb_i;
    assign busWrite  = busReq & wb_we_i & wb_ack_o;
    assign busRead   = busReq & ~wb_we_i & ~wb_ack_o;
    assign lowByte   = wb_sel_i[0];
    assign hitCtrl   = (wb_adr_i == ADDR_WIDTH'(CTRL_OFFSET));
    assign hitStatus = (wb_adr_i == ADDR_WIDTH'(STATUS_OFFSET));
    assign hitEvent  = (wb_adr_i == ADDR_WIDTH'(EVENT_OFFSET));
    assign hitMask   = (wb_adr_i == ADDR_WIDTH'(MASK_OFFSET));

    // One wait state; ack drops the cycle after it was given
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= busReq & ~wb_ack_o;
        end
    end

    // Read data is captured at the edge that raises ack
    always_comb
    begin
        readData = 32'h0000_0000;
        if (hitCtrl)
        begin
            readData[CTRL_WIDTH-1:0] = ctrl;
        end
        else if (hitStatus)
        begin
            readData[STATE_MSB:STATE_LSB] = stateToCode(state);
            readData[BTN_FLAG_BIT]        = removalButtonFlag;
            readData[CHG_FLAG_BIT]        = statusChangeFlag;
            readData[PRES_B_BIT]          = presNow[1];
            readData[PRES_A_BIT]          = presNow[0];
        end
        else if (hitEvent)
        begin
            readData[EVT_WIDTH-1:0] = eventStatus;
        end
        else if (hitMask)
        begin
            readData[EVT_WIDTH-1:0] = eventMask;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else if (busRead)
        begin
            wb_dat_o <= readData;
        end
    end

    // Control and enable register; upper bytes have no storage
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl <= CTRL_RESET;
        end
        else if (busWrite & hitCtrl & lowByte)
        begin
            ctrl <= wb_dat_i[CTRL_WIDTH-1:0];
        end
    end

    assign requestedCode = ctrl[REQ_MSB:REQ_LSB];
    assign bayInterlock  = ctrl[INTERLOCK_BIT];
    assign bayPower      = ctrl[POWER_BIT];

    // A request acts once per write, so a stale code cannot fight later
    // presence-driven changes of the state
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reqPending <= 1'b0;
        end
        else
        begin
            reqPending <= busWrite & hitCtrl & lowByte
                          & codeValid(wb_dat_i[REQ_MSB:REQ_LSB]);
        end
    end

    // Pins pass two flip-flops before any logic looks at them
    bay_sync #(
        .WIDTH (3)
    ) pinSync (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .asyncIn ({removalButton, presencePins}),
        .syncOut (syncPins)
    );

    assign presNow   = syncPins[1:0];
    assign buttonNow = syncPins[2];

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            presPrev   <= 2'h0;
            buttonPrev <= 1'b0;
        end
        else
        begin
            presPrev   <= presNow;
            buttonPrev <= buttonNow;
        end
    end

    assign presChange = |(presNow ^ presPrev);
    assign removalEvt = (|presPrev) & ~(|presNow);
    assign insertEvt  = ~(|presPrev) & (|presNow);

    // A removal in the removal-allowed state is gated by the wake enable
    assign chgSet = presChange
                    & ~(removalEvt & (state == ST_REM_ALLOWED)
                        & ~ctrl[WAKE_EN_BIT]);

    // Button press counts only with a device in the bay
    assign btnSet = buttonNow & ~buttonPrev & (|presNow);

    // Sticky flags: write one to clear, a set in the same cycle wins
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            removalButtonFlag <= 1'b0;
        end
        else if (btnSet)
        begin
            removalButtonFlag <= 1'b1;
        end
        else if (busWrite & hitStatus & lowByte & wb_dat_i[BTN_FLAG_BIT])
        begin
            removalButtonFlag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            statusChangeFlag <= 1'b0;
        end
        else if (chgSet)
        begin
            statusChangeFlag <= 1'b1;
        end
        else if (busWrite & hitStatus & lowByte & wb_dat_i[CHG_FLAG_BIT])
        begin
            statusChangeFlag <= 1'b0;
        end
    end

    // Internal interrupt from flag and enable pairs
    assign bayIrq = (removalButtonFlag & ctrl[BTN_IRQ_EN_BIT])
                    | (statusChangeFlag & ctrl[CHG_IRQ_EN_BIT]);

    // Bay state: presence wins over a software request in the same cycle
    always_comb
    begin
        next_state = state;
        if (removalEvt)
        begin
            next_state = ST_EMPTY;
        end
        else if (insertEvt & (state == ST_EMPTY))
        begin
            next_state = ST_INSERTED;
        end
        else if (reqPending)
        begin
            next_state = codeToState(requestedCode);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= ST_EMPTY;
        end
        else
        begin
            case (next_state)
                ST_EMPTY,
                ST_INSERTED,
                ST_ENABLED,
                ST_REM_REQ,
                ST_REM_ALLOWED: state <= next_state;
                default:        state <= ST_EMPTY;
            endcase
        end
    end

    assign stateChanged   = (next_state != state);
    assign bayActualState = stateToCode(state);

    // Read-clear at the capture edge, so no event slips in unread
    always_comb
    begin
        newEvents                = '0;
        newEvents[EVT_BTN_BIT]   = btnSet;
        newEvents[EVT_CHG_BIT]   = chgSet;
        newEvents[EVT_STATE_BIT] = stateChanged;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            eventStatus <= EVENT_RESET;
        end
        else if (busRead & hitEvent)
        begin
            eventStatus <= newEvents;
        end
        else
        begin
            eventStatus <= eventStatus | newEvents;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            eventMask <= MASK_RESET;
        end
        else if (busWrite & hitMask & lowByte)
        begin
            eventMask <= wb_dat_i[EVT_WIDTH-1:0];
        end
    end

    // Level output, derived only from flip-flops
    assign irq = |(eventStatus & eventMask);

endmodule

// ---- verilog/bay_ctrl_pkg.sv ----
// Register map, field layout and state codes of the device bay controller
package bay_ctrl_pkg;

    // Register byte offsets on the register bus
    localparam logic [7:0]  STATUS_OFFSET    = 8'hB0;
    localparam logic [7:0]  CTRL_OFFSET      = 8'hB4;
    localparam logic [7:0]  EVENT_OFFSET     = 8'hC0;
    localparam logic [7:0]  MASK_OFFSET      = 8'hC4;

    // Reset values
    localparam logic [7:0]  CTRL_RESET       = 8'h00;
    localparam logic [2:0]  EVENT_RESET      = 3'h0;
    localparam logic [2:0]  MASK_RESET       = 3'h0;

    // Control and enable register fields
    localparam int          INTERLOCK_BIT    = 7;
    localparam int          REQ_MSB          = 6;
    localparam int          REQ_LSB          = 4;
    localparam int          BTN_IRQ_EN_BIT   = 3;
    localparam int          CHG_IRQ_EN_BIT   = 2;
    localparam int          WAKE_EN_BIT      = 1;
    localparam int          POWER_BIT        = 0;
    localparam int          CTRL_WIDTH       = 8;

    // Status register fields
    localparam int          STATE_MSB        = 6;
    localparam int          STATE_LSB        = 4;
    localparam int          BTN_FLAG_BIT     = 3;
    localparam int          CHG_FLAG_BIT     = 2;
    localparam int          PRES_B_BIT       = 1;
    localparam int          PRES_A_BIT       = 0;

    // Event status and mask register fields
    localparam int          EVT_BTN_BIT      = 0;
    localparam int          EVT_CHG_BIT      = 1;
    localparam int          EVT_STATE_BIT    = 2;
    localparam int          EVT_WIDTH        = 3;

    // Synchroniser depth for pins
    localparam int          SYNC_STAGES      = 2;

    // Three-bit bay state codes, requested and actual
    localparam logic [2:0]  CODE_NO_CHANGE   = 3'h0;
    localparam logic [2:0]  CODE_EMPTY       = 3'h0;
    localparam logic [2:0]  CODE_INSERTED    = 3'h1;
    localparam logic [2:0]  CODE_ENABLED     = 3'h2;
    localparam logic [2:0]  CODE_REM_REQ     = 3'h3;
    localparam logic [2:0]  CODE_REM_ALLOWED = 3'h4;

    // Bay state, one-hot
    typedef enum logic [4:0]
    {
        ST_EMPTY       = 5'b00001,
        ST_INSERTED    = 5'b00010,
        ST_ENABLED     = 5'b00100,
        ST_REM_REQ     = 5'b01000,
        ST_REM_ALLOWED = 5'b10000
    } bayState_type;

endpackage

// ---- verilog/bay_sync.sv ----
// Two-stage synchroniser for asynchronous pins
module bay_sync
    import bay_ctrl_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    // Pins and their synchronised copy
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] firstStage;

    // First stage feeds only the second one
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            firstStage <= '0;
            syncOut    <= '0;
        end
        else
        begin
            firstStage <= asyncIn;
            syncOut    <= firstStage;
        end
    end

endmodule

// ---- tb/bay_partner.sv ----
// Behavioural bay: presence pins and removal button
module bay_partner
(
    // Clock
    input  wire logic       sys_clk,
    // Commands from the bench
    input  wire logic [1:0] want,
    input  wire logic       press,
    // Bay pins
    output logic      [1:0] presencePins,
    output logic            removalButton
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins move on the bus clock; real pins are asynchronous, the
    // synchroniser in the block covers both cases
    initial
    begin
        presencePins = 2'h0;
        removalButton = 1'h0;
    end
    always @(posedge sys_clk)
    begin
        presencePins <= want;
        removalButton <= press;
    end
endmodule

// ---- tb/bay_ctrl_checker.sv ----
// Port-level assertions for the bay control block
module bay_ctrl_checker
    import bay_ctrl_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
)
(
    // Clock and reset
    input wire logic                  sys_clk,
    input wire logic                  reset_n,
    // Register bus
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic                  wb_we_i,
    input wire logic [ADDR_WIDTH-1:0] wb_adr_i,
    input wire logic [3:0]            wb_sel_i,
    input wire logic [31:0]           wb_dat_i,
    input wire logic [31:0]           wb_dat_o,
    input wire logic                  wb_ack_o,
    // Bay side
    input wire logic [1:0]            presencePins,
    input wire logic                  bayInterlock,
    input wire logic                  bayPower,
    input wire logic [2:0]            bayActualState,
    input wire logic                  bayIrq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       ctrlWr;
    logic       codeOk;
    logic [7:0] ctrlCopy;
    logic [1:0] pinsDly;
    logic [2:0] quiet;
    assign ctrlWr = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i
        && wb_adr_i == CTRL_OFFSET && wb_sel_i[0];
    assign codeOk = wb_dat_i[6:4] inside {[3'h1:3'h4]};
    always_ff @(posedge sys_clk or negedge reset_n)
        if (!reset_n)
            ctrlCopy <= CTRL_RESET;
        else if (ctrlWr)
            ctrlCopy <= wb_dat_i[7:0];
    // Requests are judged only with quiet pins, presence events win
    always_ff @(posedge sys_clk or negedge reset_n)
        if (!reset_n)
        begin
            pinsDly <= 2'h0;
            quiet <= 3'h0;
        end
        else
        begin
            pinsDly <= presencePins;
            quiet <= (presencePins != pinsDly) ? 3'h0
                : quiet + {2'h0, quiet != 3'h7};
        end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence ctrlWrite;
        ctrlWr;
    endsequence
    sequence stateReq;
        ctrlWr && quiet > 3'h3;
    endsequence
    a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing");
    a_ctrl_readback: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i == CTRL_OFFSET
        |-> wb_dat_o == {24'h0, ctrlCopy}) else $error("ctrl read");
    a_power_write: assert property (
        ctrlWrite |=> bayPower == $past(wb_dat_i[0])) else $error("power");
    a_interlock_follows: assert property (
        bayInterlock == ctrlCopy[7]) else $error("interlock");
    a_request_moves: assert property (
        stateReq ##0 codeOk |-> ##2 bayActualState == $past(wb_dat_i[6:4], 2))
        else $error("request");
    a_code_no_effect: assert property (
        stateReq ##0 !codeOk |-> ##2
        bayActualState == $past(bayActualState, 2)) else $error("code");
    a_irq_disabled: assert property (
        !ctrlCopy[3] && !ctrlCopy[2] |-> !bayIrq) else $error("irq off");
    a_state_legal: assert property (
        bayActualState <= CODE_REM_ALLOWED) else $error("state code");
endmodule
bind device_bay_control_enable bay_ctrl_checker #(.ADDR_WIDTH(ADDR_WIDTH))
    i_chk (.sys_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .presencePins,
    .bayInterlock, .bayPower, .bayActualState, .bayIrq);

// ---- tb/tb.sv ----
// Self-checking bench for the bay control and enable block
module tb
    import bay_ctrl_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rdata;
    logic [1:0]  presencePins, want;
    logic        removalButton, bayPower, bayInterlock, bayIrq, irq, press;
    logic [2:0]  bayActualState, st;
    logic [2:0]  codes [9] = '{3'h2, 3'h3, 3'h4, 3'h1, 3'h5, 3'h6, 3'h7,
        3'h0, 3'h4};
    int          fails = 0;
    int          checks = 0;
    always #4 sys_clk = ~sys_clk;
    device_bay_control_enable i_dut (.sys_clk, .reset_n, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .presencePins, .removalButton, .bayPower, .bayInterlock,
        .bayActualState, .bayIrq, .irq);
    bay_partner i_bay (.sys_clk, .want, .press, .presencePins,
        .removalButton);
    task automatic summarize;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] e,
        input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // One classic cycle; request held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        n = 0;
        do
            @(posedge sys_clk);
        while (wb_ack_o !== 1'h1 && ++n < 50);
        rdata = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        if (wb_ack_o !== 1'h1)
        begin
            fails++;
            summarize();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input string n);
        bus(1'h0, a, 32'h0);
        cmp(n, e, rdata);
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge sys_clk);
    endtask
    task automatic pins(input logic [1:0] p, input logic b);
        want <= p;
        press <= b;
        idle(8);
    endtask
    initial
    begin
        sys_clk = 1'h0;
        reset_n = 1'h0;
        {wb_cyc_i, wb_stb_i, wb_we_i, want, press} = 6'h00;
        wb_adr_i = 8'h0;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'h1;
        rd(CTRL_OFFSET, 32'h0, "ctrl");
        rd(STATUS_OFFSET, 32'h0, "status");
        rd(8'h40, 32'h0, "unmapped");
        bus(1'h1, CTRL_OFFSET, 32'hFFFFFFFF);
        rd(CTRL_OFFSET, 32'hFF, "ctrl");
        cmp("power", 32'h1, bayPower);
        cmp("lock", 32'h1, bayInterlock);
        cmp("state", 32'h0, bayActualState);
        bus(1'h1, CTRL_OFFSET, 32'h0);
        idle(1);
        cmp("power", 32'h0, bayPower);
        cmp("lock", 32'h0, bayInterlock);
        pins(2'h1, 1'h0);
        rd(STATUS_OFFSET, 32'h15, "status");
        bus(1'h1, STATUS_OFFSET, 32'h4);
        rd(STATUS_OFFSET, 32'h11, "status");
        rd(EVENT_OFFSET, 32'h6, "event");
        rd(EVENT_OFFSET, 32'h0, "event");
        st = CODE_INSERTED;
        foreach (codes[i])
        begin
            bus(1'h1, CTRL_OFFSET, {25'h0, codes[i], 4'h0});
            idle(2);
            if (codes[i] inside {[3'h1:3'h4]})
                st = codes[i];
            cmp("state", st, bayActualState);
        end
        bus(1'h1, CTRL_OFFSET, 32'h44);
        pins(2'h0, 1'h0);
        rd(STATUS_OFFSET, 32'h0, "status");
        pins(2'h2, 1'h0);
        rd(STATUS_OFFSET, 32'h16, "status");
        cmp("bayIrq", 32'h1, bayIrq);
        bus(1'h1, STATUS_OFFSET, 32'h4);
        idle(1);
        cmp("bayIrq", 32'h0, bayIrq);
        bus(1'h1, CTRL_OFFSET, 32'h46);
        pins(2'h0, 1'h0);
        rd(STATUS_OFFSET, 32'h4, "status");
        bus(1'h1, STATUS_OFFSET, 32'h4);
        bus(1'h1, MASK_OFFSET, 32'h1);
        bus(1'h1, CTRL_OFFSET, 32'h8);
        pins(2'h1, 1'h0);
        rd(EVENT_OFFSET, 32'h6, "event");
        cmp("bayIrq", 32'h0, bayIrq);
        pins(2'h1, 1'h1);
        cmp("bayIrq", 32'h1, bayIrq);
        cmp("irq", 32'h1, irq);
        rd(STATUS_OFFSET, 32'h1D, "status");
        rd(EVENT_OFFSET, 32'h1, "event");
        idle(1);
        cmp("irq", 32'h0, irq);
        bus(1'h1, CTRL_OFFSET, 32'h0);
        bus(1'h1, MASK_OFFSET, 32'h0);
        pins(2'h1, 1'h0);
        pins(2'h1, 1'h1);
        cmp("bayIrq", 32'h0, bayIrq);
        cmp("irq", 32'h0, irq);
        summarize();
    end
endmodule
